// ==== src/wcab_inv_if.sv ====
// bundle between the top and the lane inversion codec
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
`default_nettype none
interface wcab_inv_if;
	import wcab_pkg::*;
	logic [LANES*LANE_W-1:0] wr_data;   // received write beat
	logic [LANES-1:0]        wr_flag_n; // sampled lane flags
	logic [LANES-1:0]        wr_en;     // per-lane write inversion on
	logic [LANES*LANE_W-1:0] wr_out;    // data to store
	logic [LANES*LANE_W-1:0] rd_data;   // array read beat
	logic [LANES-1:0]        rd_en;     // per-lane read inversion on
	logic [LANES*LANE_W-1:0] rd_out;    // data to drive
	logic [LANES-1:0]        rd_flag_n; // lane flags to drive
	modport top (output wr_data, wr_flag_n, wr_en, rd_data, rd_en,
		input wr_out, rd_out, rd_flag_n);
	modport codec (input wr_data, wr_flag_n, wr_en, rd_data, rd_en,
		output wr_out, rd_out, rd_flag_n);
endinterface
`default_nettype wire

// ==== src/wcab_lane_codec.sv ====
// per-lane bus inversion encode and decode, purely combinational
// assumes the top registers everything around it
`timescale 1ns/100ps
`default_nettype none
module wcab_lane_codec
	import wcab_pkg::*;
(
	// inversion bundle
	wcab_inv_if.codec io
);
	genvar g;
	// one copy per byte lane
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			wire logic [LANE_W-1:0] wd;
			wire logic [LANE_W-1:0] rd;
			wire logic [3:0]        zeros;
			wire logic              rd_inv;
			wire logic              wr_inv;
			assign wd = io.wr_data[g*LANE_W +: LANE_W];
			assign rd = io.rd_data[g*LANE_W +: LANE_W];
			// flag low means the controller sent the byte inverted
			assign wr_inv = io.wr_en[g] & ~io.wr_flag_n[g];
			assign io.wr_out[g*LANE_W +: LANE_W] = wr_inv ? ~wd : wd;
			// invert when more than half the bits would drive low
			assign zeros = 4'($countones(~rd));
			assign rd_inv = io.rd_en[g] & (zeros > ZERO_LIMIT);
			assign io.rd_out[g*LANE_W +: LANE_W] = rd_inv ? ~rd : rd;
			// flag is active low: high for a plain byte
			assign io.rd_flag_n[g] = ~rd_inv;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== src/wcab_pkg.sv ====
// package for the write check alert and bus inversion block
// assumes one 20 MHz clock and an apb register port with 32-bit data
package wcab_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_MODE_FIVE  = 8'h00;
	localparam logic [7:0] ADDR_MODE_ONE   = 8'h04;
	localparam logic [7:0] ADDR_READOUT3   = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
	localparam logic [7:0] ADDR_CFG        = 8'h14;
	// field positions
	localparam int M5_CRC_ERR   = 3;
	localparam int M5_MASK_EN   = 10;
	localparam int M5_WINV_EN   = 11;
	localparam int M5_RINV_EN   = 12;
	localparam int M1_TSTRB_EN  = 11;
	localparam int RO3_CRC_FLAG = 7;
	localparam int IRQ_CRC      = 0;
	localparam int IRQ_CA       = 1;
	// software-writable mode five bits (status bit handled apart)
	localparam logic [31:0] M5_WR_MASK = 32'h0000_1C00;
	localparam logic [31:0] M1_WR_MASK = 32'h0000_0800;
	// reset values
	localparam logic [31:0] MODE_FIVE_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_ONE_RST  = 32'h0000_0000;
	localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
	// device organisation codes held in the cfg register
	typedef enum logic [1:0] {
		WCAB_X4  = 2'h0,
		WCAB_X8  = 2'h1,
		WCAB_X16 = 2'h2
	} wcab_width_t;
	localparam logic [1:0] CFG_RST = 2'h2;
	// alert timing, in clocks
	localparam logic [5:0] CRC_PULSE_CLKS = 6'h0A;
	localparam logic [5:0] CA_HOLD_CLKS   = 6'h2E;
	// lane geometry and read inversion threshold
	localparam int LANES  = 2;
	localparam int LANE_W = 8;
	localparam logic [3:0] ZERO_LIMIT = 4'h4;
	// alert line states
	typedef enum logic [1:0] {
		WCAB_IDLE    = 2'b00,
		WCAB_CRC_LOW = 2'b01,
		WCAB_CA_LOW  = 2'b10
	} wcab_alert_t;
endpackage

// ==== src/wcab_top.sv ====
// top of the write check alert and bus inversion block
// assumes crc_mismatch and ca_error are one-cycle pulses from pclk logic,
// data beats arrive already on pclk, and the board pulls the alert line up
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module wcab_top
	import wcab_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// error events from the check logic
	input  wire logic        crc_mismatch,
	input  wire logic        ca_error,
	// write beat in, stored data out
	input  wire logic        wr_valid,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_flag_n,
	output logic             store_valid,
	output logic      [15:0] store_data,
	// read beat in, driven data out
	input  wire logic        rd_valid,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_readout,
	output logic             rd_out_valid,
	output logic      [15:0] rd_dq,
	output logic      [1:0]  rd_flag_n,
	// open-drain alert line and interrupt
	output logic             alert_out,
	output logic             alert_oe,
	output logic             irq
);
	// register state
	logic [31:0] mode_five_q, mode_five_d; // inversion, mask, crc status
	logic [31:0] mode_one_q;               // termination strobe enable
	logic [1:0]  cfg_q;                    // device organisation
	logic [1:0]  irq_stat_q, irq_stat_d;   // sticky event bits
	logic [1:0]  irq_mask_q;               // event enables
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, irq_q;
	// alert line state
	wcab_alert_t st_q, st_d;
	logic [5:0]  cnt_q, cnt_d;
	logic        alert_oe_q, alert_q;
	// data path outputs
	logic        store_valid_q, rd_out_valid_q;
	logic [15:0] store_data_q, rd_dq_q;
	logic [1:0]  rd_flag_q;

	wcab_inv_if io ();

	// bus decode
	wire logic setup  = psel & ~penable;
	wire logic access = psel & penable & pready_q;
	wire logic wr_acc = access & pwrite;
	wire logic sel_m5 = paddr == ADDR_MODE_FIVE;
	wire logic sel_m1 = paddr == ADDR_MODE_ONE;
	wire logic sel_r3 = paddr == ADDR_READOUT3;
	wire logic sel_st = paddr == ADDR_IRQ_STAT;
	wire logic sel_mk = paddr == ADDR_IRQ_MASK;
	wire logic sel_cf = paddr == ADDR_CFG;
	wire logic hit = sel_m5 | sel_m1 | sel_r3 | sel_st | sel_mk | sel_cf;
	wire logic crc_clear = wr_acc & sel_m5 & ~pwdata[M5_CRC_ERR];
	// readout location three mirrors the status bit
	wire logic [31:0] ro3_word =
		32'(mode_five_q[M5_CRC_ERR]) << RO3_CRC_FLAG;
	wire logic [31:0] rd_word =
		sel_m5 ? mode_five_q :
		sel_m1 ? mode_one_q :
		sel_r3 ? ro3_word :
		sel_st ? {30'h0, irq_stat_q} :
		sel_mk ? {30'h0, irq_mask_q} :
		sel_cf ? {30'h0, cfg_q} : 32'h0;

	// apb answers: one wait-free access cycle after each setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			prdata_q  <= setup ? rd_word : prdata_q;
		end
	end

	// mode five next value
	always_comb begin
		mode_five_d = mode_five_q;
		if (wr_acc && sel_m5) begin
			mode_five_d = (mode_five_q & ~M5_WR_MASK) | (pwdata & M5_WR_MASK);
		end
		if (crc_clear) begin
			mode_five_d[M5_CRC_ERR] = 1'b0;
		end
		// mismatch sets status
		// a mismatch in the clearing cycle wins so no error is lost
		if (crc_mismatch) begin
			mode_five_d[M5_CRC_ERR] = 1'b1;
		end
	end

	// sticky events, write one to clear, new events win
	assign irq_stat_d = (irq_stat_q & ~((wr_acc & sel_st) ? pwdata[1:0] : 2'h0))
		| {ca_error, crc_mismatch};

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_five_q <= MODE_FIVE_RST;
			mode_one_q  <= MODE_ONE_RST;
			cfg_q       <= CFG_RST;
			irq_mask_q  <= IRQ_MASK_RST;
			irq_stat_q  <= 2'h0;
			irq_q       <= 1'b0;
		end else begin
			mode_five_q <= mode_five_d;
			mode_one_q  <= (wr_acc && sel_m1) ? (pwdata & M1_WR_MASK) : mode_one_q;
			cfg_q       <= (wr_acc && sel_cf) ? pwdata[1:0] : cfg_q;
			irq_mask_q  <= (wr_acc && sel_mk) ? pwdata[1:0] : irq_mask_q;
			irq_stat_q  <= irq_stat_d;
			irq_q       <= |(irq_stat_q & irq_mask_q);
		end
	end

	// alert line sequencing: parity holds outrank short crc pulses
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		unique case (st_q)
			WCAB_IDLE: begin
				st_d = st_q;
			end
			WCAB_CRC_LOW, WCAB_CA_LOW: begin
				// count down, release at zero
				if (cnt_q == 6'h0) begin
					st_d = WCAB_IDLE;
				end else begin
					cnt_d = cnt_q - 6'h01;
				end
			end
			default: begin
				st_d = WCAB_IDLE;
			end
		endcase
		// short pulse for crc
		// a later crc restarts the pulse; the line just stays low longer
		if (crc_mismatch && st_q != WCAB_CA_LOW) begin
			st_d  = WCAB_CRC_LOW;
			cnt_d = CRC_PULSE_CLKS - 6'h01;
		end
		if (ca_error) begin
			st_d  = WCAB_CA_LOW;
			cnt_d = CA_HOLD_CLKS - 6'h01;
		end
	end

	// alert flops; the pin value is a constant low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= WCAB_IDLE;
			cnt_q      <= 6'h0;
			alert_oe_q <= 1'b0;
			alert_q    <= 1'b0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			alert_oe_q <= st_d != WCAB_IDLE;
			alert_q    <= 1'b0;
		end
	end

	// inversion enables
	wire logic wide   = cfg_q != WCAB_X4;
	wire logic x16    = cfg_q == WCAB_X16;
	wire logic tstrb  = mode_one_q[M1_TSTRB_EN];
	// legal combinations only
	// masking shares the flag pin, so it blocks write inversion here too
	wire logic wr_inv = mode_five_q[M5_WINV_EN] & ~mode_five_q[M5_MASK_EN]
		& ~tstrb;
	wire logic rd_inv = mode_five_q[M5_RINV_EN] & ~tstrb & ~rd_readout;
	assign io.wr_en     = {x16, wide} & {2{wr_inv}};
	assign io.rd_en     = {x16, wide} & {2{rd_inv}};
	assign io.wr_data   = wr_data;
	assign io.wr_flag_n = wr_flag_n;
	assign io.rd_data   = rd_data;

	wcab_lane_codec u_codec (
		.io (io.codec)
	);

	// beat registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_valid_q  <= 1'b0;
			store_data_q   <= 16'h0;
			rd_out_valid_q <= 1'b0;
			rd_dq_q        <= 16'h0;
			rd_flag_q      <= 2'h3;
		end else begin
			store_valid_q  <= wr_valid;
			store_data_q   <= wr_valid ? io.wr_out : store_data_q;
			rd_out_valid_q <= rd_valid;
			rd_dq_q        <= rd_valid ? io.rd_out : rd_dq_q;
			rd_flag_q      <= rd_valid ? io.rd_flag_n : 2'h3;
		end
	end

	// outputs straight from flops
	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign store_valid  = store_valid_q;
	assign store_data   = store_data_q;
	assign rd_out_valid = rd_out_valid_q;
	assign rd_dq        = rd_dq_q;
	assign rd_flag_n    = rd_flag_q;
	assign alert_out    = alert_q;
	assign alert_oe     = alert_oe_q;
	assign irq          = irq_q;

	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_alert_pull_only: assert property (
		alert_out == 1'b0)
		else $error("alert pin driven high");
	a_crc_pulse_len: assert property (
		(crc_mismatch && !ca_error && st_q == WCAB_IDLE) ##1
		(!crc_mismatch && !ca_error)[*8] ##1 (!crc_mismatch && !ca_error)
		##1 (!crc_mismatch && !ca_error) |-> ##1 !alert_oe)
		else $error("crc pulse not ten clocks");
	a_crc_pulse_on: assert property (
		crc_mismatch |=> alert_oe)
		else $error("crc did not pull alert");
	a_ca_hold_long: assert property (
		ca_error |=> alert_oe[*8] ##38 alert_oe)
		else $error("parity hold too short");
	a_status_set: assert property (
		crc_mismatch |=> mode_five_q[M5_CRC_ERR] && ro3_word[RO3_CRC_FLAG])
		else $error("crc status not set");
	a_status_sticky: assert property (
		mode_five_q[M5_CRC_ERR] && !crc_clear |=> mode_five_q[M5_CRC_ERR])
		else $error("crc status dropped");
	a_mirror_flag: assert property (
		crc_clear && !crc_mismatch |=> !ro3_word[RO3_CRC_FLAG])
		else $error("mirror flag not cleared");
	a_nibble_plain: assert property (
		rd_valid && cfg_q == WCAB_X4 |=> rd_flag_n == 2'h3 &&
		rd_dq == $past(rd_data))
		else $error("inversion on nibble part");
	a_readout_plain: assert property (
		rd_valid && rd_readout |=> rd_flag_n == 2'h3 && rd_dq == $past(rd_data))
		else $error("readout read inverted");
	a_write_invert: assert property (
		wr_valid && wr_inv && wide && !wr_flag_n[0] |=>
		store_data[7:0] == ~$past(wr_data[7:0]))
		else $error("write lane not decoded");
	a_read_invert: assert property (
		rd_valid && rd_inv && wide && $countones(~rd_data[7:0]) > 4 |=>
		!rd_flag_n[0] && rd_dq[7:0] == ~$past(rd_data[7:0]))
		else $error("read lane not encoded");
	a_upper_flag: assert property (
		rd_valid && rd_inv && x16 && $countones(~rd_data[15:8]) <= 4 |=>
		rd_flag_n[1] && rd_dq[15:8] == $past(rd_data[15:8]))
		else $error("upper lane flag wrong");
	a_irq_from_crc: assert property (
		crc_mismatch && irq_mask_q[IRQ_CRC] && !(wr_acc && sel_mk) |=> ##1 irq)
		else $error("crc interrupt missing");

	c_crc_pulse: cover property (crc_mismatch ##1 alert_oe);
	c_ca_hold: cover property (ca_error ##1 alert_oe[*8]);
	c_read_inv: cover property (rd_valid && rd_inv ##1 !rd_flag_n[0]);
	c_write_inv: cover property (wr_valid && wr_inv && !wr_flag_n[0]);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: register checks, lane inversion beats, alert pulses
// assumes the controller model supplies the alert pull-up
`timescale 1ns/100ps
`default_nettype none
module tb;
	import wcab_pkg::*;
	logic        pclk = 1'b0;        // 20 MHz clock
	logic        presetn = 1'b0;     // async reset
	logic [7:0]  paddr = 8'h00;      // apb request
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;             // apb answer
	logic        pready;
	logic        pslverr;
	logic        crc_mismatch = 1'b0; // error events
	logic        ca_error = 1'b0;
	logic        wr_valid = 1'b0;    // write beat
	logic [15:0] wr_data = 16'h0;
	logic [1:0]  wr_flag_n = 2'h3;
	logic        store_valid;
	logic [15:0] store_data;
	logic        rd_valid = 1'b0;    // read beat
	logic [15:0] rd_data = 16'h0;
	logic        rd_readout = 1'b0;
	logic        rd_out_valid;
	logic [15:0] rd_dq;
	logic [1:0]  rd_flag_n;
	logic        alert_out;          // alert driver and line
	logic        alert_oe;
	logic        alert_line;
	logic [7:0]  low_len;
	logic [7:0]  retries;            // writes replayed by the controller
	logic        irq;
	logic [31:0] seed = 32'h0000_EB35; // fixed seed
	int          mismatches = 0;
	int          comparisons = 0;

	wcab_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .crc_mismatch, .ca_error,
		.wr_valid, .wr_data, .wr_flag_n, .store_valid, .store_data,
		.rd_valid, .rd_data, .rd_readout, .rd_out_valid, .rd_dq,
		.rd_flag_n, .alert_out, .alert_oe, .irq);
	wcab_ctrl_model i_ctrl (.pclk, .presetn, .alert_out, .alert_oe,
		.alert_line, .low_len, .retries);

	// free-running clock
	initial begin
		forever #25 pclk = ~pclk;
	end

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one comparison of a design value
	task automatic chk(input string nm, input logic [31:0] x, got);
		comparisons++;
		if (got !== x) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, got);
		end
	endtask

	// one edge of a bounded wait; a spent bound ends the run
	task automatic tick_or_die(input int n);
		if (n > 200) begin
			mismatches++;
			report_and_stop();
		end else begin
			@(posedge pclk);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			n++;
			tick_or_die(n);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next request never re-drives psel here
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, x, r);
	endtask

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// stored write beat: lane flipped when its flag is low
	function automatic logic [15:0] wexp(logic [15:0] d, logic [1:0] f,
		logic [1:0] en);
		for (int i = 0; i < 2; i++) begin
			if (en[i] && !f[i]) d[i*8 +: 8] = ~d[i*8 +: 8];
		end
		return d;
	endfunction

	// driven read beat {flags, data}: flip when over four zeros
	function automatic logic [17:0] rexp(logic [15:0] d, logic [1:0] en);
		logic [1:0] f;
		f = 2'h3;
		for (int i = 0; i < 2; i++) begin
			if (en[i] && $countones(d[i*8 +: 8]) < 4) begin
				d[i*8 +: 8] = ~d[i*8 +: 8];
				f[i] = 1'b0;
			end
		end
		return {f, d};
	endfunction

	// one write and one read beat, results looked at a cycle later
	task automatic beat(input logic [15:0] wd, input logic [1:0] wf,
		input logic [15:0] rdd, input logic ro, input logic [1:0] wen,
		input logic [1:0] ren);
		wr_valid <= 1'b1;
		wr_data <= wd;
		wr_flag_n <= wf;
		rd_valid <= 1'b1;
		rd_data <= rdd;
		rd_readout <= ro;
		@(posedge pclk);
		wr_valid <= 1'b0;
		rd_valid <= 1'b0;
		@(posedge pclk);
		chk("store_valid", 32'h1, {31'h0, store_valid});
		chk("store", {16'h0, wexp(wd, wf, wen)}, {16'h0, store_data});
		chk("rd_out_valid", 32'h1, {31'h0, rd_out_valid});
		chk("rd_beat", {14'h0, rexp(rdd, ro ? 2'h0 : ren)}, {14'h0, rd_flag_n, rd_dq});
	endtask

	// pulse one event, then measure the line's low width
	task automatic alert(input logic crc, input int gap,
		input logic [7:0] w);
		int n;
		n = 0;
		crc_mismatch <= crc;
		ca_error <= !crc;
		@(posedge pclk);
		crc_mismatch <= 1'b0;
		ca_error <= 1'b0;
		// a second crc gap edges later stretches the low period
		if (gap > 1) begin
			repeat (gap - 1) @(posedge pclk);
			crc_mismatch <= 1'b1;
			@(posedge pclk);
			crc_mismatch <= 1'b0;
		end
		do begin
			n++;
			tick_or_die(n);
		end while (alert_line !== 1'b0);
		chk("alert_out", 32'h0, {31'h0, alert_out});
		do begin
			n++;
			tick_or_die(n);
		end while (alert_line !== 1'b1);
		@(posedge pclk);
		chk("low_len", {24'h0, w}, {24'h0, low_len});
	endtask

	// main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		logic [1:0]  en;
		logic        ro;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("mode_five", ADDR_MODE_FIVE, MODE_FIVE_RST);
		rd("mode_one", ADDR_MODE_ONE, MODE_ONE_RST);
		rd("readout3", ADDR_READOUT3, 32'h0);
		rd("irq_stat", ADDR_IRQ_STAT, 32'h0);
		rd("irq_mask", ADDR_IRQ_MASK, {30'h0, IRQ_MASK_RST});
		rd("cfg", ADDR_CFG, {30'h0, CFG_RST});
		// unmapped word answers with an error and zero data
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("pslverr", 32'h1, {31'h0, e});
		chk("bad_rdata", 32'h0, r);
		wr(ADDR_MODE_FIVE, 32'h0000_1800);
		// every width, corner beats first, then random ones
		for (int c = 0; c < 3; c++) begin
			wr(ADDR_CFG, 32'(c));
			en = (c == 2) ? 2'h3 : (c == 1) ? 2'h1 : 2'h0;
			for (int k = 0; k < 24; k++) begin
				r = xs();
				if (k == 0) r[15:0] = 16'h070F;
				if (k == 1) r[15:0] = 16'h0100;
				if (k == 2) r[15:0] = 16'h0000;
				ro = (k == 2) || (k > 3 && r[31]);
				beat(r[31:16], r[17:16], r[15:0], ro, en, en);
			end
		end
		// masking with read inversion, then strobe alone
		wr(ADDR_MODE_FIVE, 32'h0000_1400);
		for (int k = 0; k < 8; k++) begin
			r = xs();
			beat(r[31:16], r[17:16], r[15:0], 1'b0, 2'h0, 2'h3);
		end
		wr(ADDR_MODE_FIVE, 32'h0000_0000);
		wr(ADDR_MODE_ONE, 32'h0000_0800);
		rd("mode_one_set", ADDR_MODE_ONE, 32'h0000_0800);
		beat(16'h00FF, 2'h0, 16'h0000, 1'b0, 2'h0, 2'h0);
		wr(ADDR_MODE_ONE, 32'h0000_0000);
		wr(ADDR_MODE_FIVE, 32'h0000_1800);
		// crc event: short pulse, sticky status, mirror, irq
		wr(ADDR_IRQ_MASK, 32'h1);
		alert(1'b1, 0, {2'h0, CRC_PULSE_CLKS});
		chk("retries", 32'h1, {24'h0, retries});
		// two crc errors three edges apart merge into one longer low
		alert(1'b1, 3, {2'h0, CRC_PULSE_CLKS} + 8'h03);
		chk("retries_merged", 32'h2, {24'h0, retries});
		chk("irq", 32'h1, {31'h0, irq});
		rd("mode_five", ADDR_MODE_FIVE, 32'h0000_1808);
		rd("readout3", ADDR_READOUT3, 32'h80);
		wr(ADDR_MODE_FIVE, 32'h0000_1808);
		rd("mode_five", ADDR_MODE_FIVE, 32'h0000_1808);
		wr(ADDR_MODE_FIVE, 32'h0000_1800);
		rd("mode_five", ADDR_MODE_FIVE, 32'h0000_1800);
		rd("readout3", ADDR_READOUT3, 32'h0);
		rd("irq_stat", ADDR_IRQ_STAT, 32'h1);
		wr(ADDR_IRQ_STAT, 32'h1);
		rd("irq_stat", ADDR_IRQ_STAT, 32'h0);
		chk("irq_clr", 32'h0, {31'h0, irq});
		// parity event: long hold, masked interrupt
		alert(1'b0, 0, {2'h0, CA_HOLD_CLKS});
		chk("retries_parity", 32'h2, {24'h0, retries});
		chk("irq_masked", 32'h0, {31'h0, irq});
		rd("irq_stat", ADDR_IRQ_STAT, 32'h2);
		rd("mode_five", ADDR_MODE_FIVE, 32'h0000_1800);
		report_and_stop();
	end

	// overall limit on the run
	initial begin
		repeat (100000) @(posedge pclk);
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// ==== tb/wcab_ctrl_model.sv ====
// controller-side model: pull-up on the shared alert line, low timer
// assumes alert_oe and alert_out come from the device on pclk
`timescale 1ns/100ps
`default_nettype none
module wcab_ctrl_model
	import wcab_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// device alert driver
	input  wire logic       alert_out,
	input  wire logic       alert_oe,
	// resolved line, width of the last low period, replay requests
	output logic            alert_line,
	output logic [7:0]      low_len,
	output logic [7:0]      retries
);
	logic [7:0] run_q;   // low cycles counted so far
	logic       crc_end; // a low period shorter than a parity hold ended

	assign alert_line = alert_oe ? alert_out : 1'b1;

	// anything shorter than a parity hold is crc
	// merged crc pulses from several devices included
	assign crc_end = alert_line && (run_q != 8'h00)
		&& (run_q < {2'h0, CA_HOLD_CLKS});

	// low timer and replay counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q   <= 8'h00;
			low_len <= 8'h00;
			retries <= 8'h00;
		end else if (!alert_line) begin
			run_q <= run_q + 8'h01;
		end else begin
			if (run_q != 8'h00) begin
				low_len <= run_q;
			end
			run_q <= 8'h00;
			// short low: replay the buffered writes
			if (crc_end) begin
				retries <= retries + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire
